// [core/acbsc_ctrl.sv]
`timescale 1ns/1ps
`include "acbsc_params.svh"
module acbsc_ctrl
	import acbsc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	input wire logic config_done,
	input wire logic [`ACBSC_NCELLS-1:0] core_out,
	input wire logic [`ACBSC_NPINS-1:0] core_tx,
	input wire logic [`ACBSC_NCELLS-1:0] pin_in,
	output logic tdo,
	output logic tdo_oe_n,
	output logic [`ACBSC_NCELLS-1:0] pin_out,
	output logic [`ACBSC_NPINS-1:0] serial_transceiver_pins,
	output acbsc_pkg::acbsc_mode_t mode,
	output acbsc_pkg::acbsc_tap_t tap_state
);
	import acbsc_pkg::*;

	localparam int BSR_W = `ACBSC_NCELLS + `ACBSC_NPINS;

	logic [1:0] tck_sync_q, tck_sync_d;
	logic [1:0] tms_sync_q, tms_sync_d;
	logic [1:0] tdi_sync_q, tdi_sync_d;
	logic [1:0] trst_sync_q, trst_sync_d;
	logic [1:0] cfg_sync_q, cfg_sync_d;
	logic tck_prev_q, tck_prev_d;
	logic tck_rise, tck_fall;
	acbsc_tap_t st;

	logic [`ACBSC_IR_W-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
	logic [BSR_W-1:0] bsr_sh_q, bsr_sh_d, bsr_upd_q, bsr_upd_d;
	logic byp_q, byp_d;
	logic tdo_q, tdo_d, tdo_oe_n_q, tdo_oe_n_d;
	logic [`ACBSC_NPINS-1:0] tx_q, tx_d;
	logic [`ACBSC_NCELLS-1:0] pin_q, pin_d;
	logic inv_q, inv_d;
	logic upd_pend_q, upd_pend_d;
	acbsc_mode_t mode_c, mode_n;

	// TCK, TMS, TDI, TRST_N and config_done pass two flops before any logic reads them; core_out, core_tx and pin_in do not.
	always_comb begin
		tck_sync_d = {tck_sync_q[0], tck};
		tms_sync_d = {tms_sync_q[0], tms};
		tdi_sync_d = {tdi_sync_q[0], tdi};
		trst_sync_d = {trst_sync_q[0], trst_n};
		cfg_sync_d = {cfg_sync_q[0], config_done};
		tck_prev_d = tck_sync_q[1];
	end

	assign tck_rise = tck_sync_q[1] & ~tck_prev_q;
	assign tck_fall = ~tck_sync_q[1] & tck_prev_q;

	acbsc_tap_fsm u_fsm (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.tck_rise(tck_rise),
		.tms_s(tms_sync_q[1]),
		.trst_n_s(trst_sync_q[1]),
		.state(st)
	);

	always_comb begin
		if (ir_q == `ACBSC_IR_PULSE && cfg_sync_q[1]) begin
			mode_c = ACBSC_MODE_PULSE;
		end else if (ir_q == `ACBSC_IR_TRAIN && cfg_sync_q[1]) begin
			mode_c = ACBSC_MODE_TRAIN;
		end else if (ir_q == `ACBSC_IR_EXTEST) begin
			mode_c = ACBSC_MODE_EXTEST;
		end else begin
			mode_c = ACBSC_MODE_FUNC;
		end
	end

	// Decode of the instruction that takes effect at this edge, so that Update-IR drives it.
	always_comb begin
		if (ir_d == `ACBSC_IR_PULSE && cfg_sync_q[1]) begin
			mode_n = ACBSC_MODE_PULSE;
		end else if (ir_d == `ACBSC_IR_TRAIN && cfg_sync_q[1]) begin
			mode_n = ACBSC_MODE_TRAIN;
		end else if (ir_d == `ACBSC_IR_EXTEST) begin
			mode_n = ACBSC_MODE_EXTEST;
		end else begin
			mode_n = ACBSC_MODE_FUNC;
		end
	end

	// Capture and shift of instruction and data registers on rising TCK, update on falling TCK.
	always_comb begin
		ir_sh_d = ir_sh_q;
		ir_d = ir_q;
		bsr_sh_d = bsr_sh_q;
		bsr_upd_d = bsr_upd_q;
		byp_d = byp_q;
		if (st == TEST_LOGIC_RESET) begin
			ir_d = `ACBSC_IR_RESET;
		end
		if (tck_rise) begin
			case (st)
				CAPTURE_IR: ir_sh_d = `ACBSC_IR_CAPTURE;
				SHIFT_IR: ir_sh_d = {tdi_sync_q[1], ir_sh_q[`ACBSC_IR_W-1:1]};
				CAPTURE_DR: begin
					bsr_sh_d = {core_tx, pin_in};
					byp_d = 1'b0;
				end
				SHIFT_DR: begin
					bsr_sh_d = {tdi_sync_q[1], bsr_sh_q[BSR_W-1:1]};
					byp_d = tdi_sync_q[1];
				end
				default: begin
				end
			endcase
		end
		if (tck_fall) begin
			case (st)
				UPDATE_IR: ir_d = ir_sh_q;
				UPDATE_DR: bsr_upd_d = bsr_sh_q;
				default: begin
				end
			endcase
		end
	end

	// Test data output changes on falling TCK, driven only while shifting.
	always_comb begin
		tdo_d = tdo_q;
		tdo_oe_n_d = tdo_oe_n_q;
		if (tck_fall) begin
			tdo_oe_n_d = ~(st == SHIFT_IR || st == SHIFT_DR);
			if (st == SHIFT_IR) begin
				tdo_d = ir_sh_q[0];
			end else if (st == SHIFT_DR) begin
				tdo_d = (ir_q == `ACBSC_IR_BYPASS) ? byp_q : bsr_sh_q[0];
			end
		end
	end

	// Transceiver transitions under the edge-detecting instructions.
	always_comb begin
		inv_d = inv_q;
		upd_pend_d = upd_pend_q;
		if (tck_fall) begin
			upd_pend_d = 1'b0;
			if (mode_n == ACBSC_MODE_PULSE || mode_n == ACBSC_MODE_TRAIN) begin
				if (st == UPDATE_IR || st == UPDATE_DR) begin
					inv_d = 1'b0;
				end else if (st == RUN_TEST_IDLE) begin
					inv_d = (mode_n == ACBSC_MODE_TRAIN) ? ~inv_q : 1'b1;
				end else begin
					inv_d = 1'b0;
				end
			end else begin
				inv_d = 1'b0;
			end
		end
	end

	always_comb begin
		tx_d = tx_q;
		pin_d = pin_q;
		if (mode_n == ACBSC_MODE_FUNC) begin
			tx_d = core_tx;
			pin_d = core_out;
		end else if (tck_fall) begin
			pin_d = bsr_upd_d[`ACBSC_NCELLS-1:0];
			tx_d = bsr_upd_d[BSR_W-1:`ACBSC_NCELLS] ^ {`ACBSC_NPINS{inv_d}};
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tck_sync_q <= 2'h0;
			tms_sync_q <= 2'h3;
			tdi_sync_q <= 2'h3;
			trst_sync_q <= 2'h0;
			cfg_sync_q <= 2'h0;
			tck_prev_q <= 1'b0;
			ir_sh_q <= `ACBSC_IR_RESET;
			ir_q <= `ACBSC_IR_RESET;
			bsr_sh_q <= '0;
			bsr_upd_q <= '0;
			byp_q <= 1'b0;
			tdo_q <= 1'b0;
			tdo_oe_n_q <= 1'b1;
			tx_q <= '0;
			pin_q <= '0;
			inv_q <= 1'b0;
			upd_pend_q <= 1'b0;
		end else if (ce) begin
			tck_sync_q <= tck_sync_d;
			tms_sync_q <= tms_sync_d;
			tdi_sync_q <= tdi_sync_d;
			trst_sync_q <= trst_sync_d;
			cfg_sync_q <= cfg_sync_d;
			tck_prev_q <= tck_prev_d;
			ir_sh_q <= ir_sh_d;
			ir_q <= ir_d;
			bsr_sh_q <= bsr_sh_d;
			bsr_upd_q <= bsr_upd_d;
			byp_q <= byp_d;
			tdo_q <= tdo_d;
			tdo_oe_n_q <= tdo_oe_n_d;
			tx_q <= tx_d;
			pin_q <= pin_d;
			inv_q <= inv_d;
			upd_pend_q <= upd_pend_d;
		end
	end

	assign tdo = tdo_q;
	assign tdo_oe_n = tdo_oe_n_q;
	assign pin_out = pin_q;
	assign serial_transceiver_pins = tx_q;
	assign mode = mode_c;
	assign tap_state = st;
endmodule

// [pkg/acbsc_params.svh]
`ifndef ACBSC_PARAMS_SVH
`define ACBSC_PARAMS_SVH
`define ACBSC_IR_W 10
`define ACBSC_IR_PULSE 10'h08F
`define ACBSC_IR_TRAIN 10'h04F
`define ACBSC_IR_EXTEST 10'h000
`define ACBSC_IR_BYPASS 10'h3FF
`define ACBSC_IR_RESET 10'h3FF
`define ACBSC_IR_CAPTURE 10'h001
`define ACBSC_NCELLS 4
`define ACBSC_NPINS 2
`endif

// [pkg/acbsc_pkg.sv]
package acbsc_pkg;
	typedef enum logic [3:0] {
		TEST_LOGIC_RESET, RUN_TEST_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR,
		PAUSE_DR, EXIT2_DR, UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR,
		PAUSE_IR, EXIT2_IR, UPDATE_IR
	} acbsc_tap_t;
	typedef enum logic [1:0] {ACBSC_MODE_FUNC, ACBSC_MODE_EXTEST, ACBSC_MODE_PULSE,
		ACBSC_MODE_TRAIN} acbsc_mode_t;
endpackage

// [core/acbsc_tap_fsm.sv]
`timescale 1ns/1ps
module acbsc_tap_fsm
	import acbsc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic tck_rise,
	input wire logic tms_s,
	input wire logic trst_n_s,
	output acbsc_pkg::acbsc_tap_t state
);
	acbsc_tap_t state_q, state_d;

	always_comb begin
		state_d = state_q;
		if (!trst_n_s) begin
			state_d = TEST_LOGIC_RESET;
		end else if (tck_rise) begin
			case (state_q)
				TEST_LOGIC_RESET: state_d = tms_s ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
				RUN_TEST_IDLE: state_d = tms_s ? SELECT_DR : RUN_TEST_IDLE;
				SELECT_DR: state_d = tms_s ? SELECT_IR : CAPTURE_DR;
				CAPTURE_DR: state_d = tms_s ? EXIT1_DR : SHIFT_DR;
				SHIFT_DR: state_d = tms_s ? EXIT1_DR : SHIFT_DR;
				EXIT1_DR: state_d = tms_s ? UPDATE_DR : PAUSE_DR;
				PAUSE_DR: state_d = tms_s ? EXIT2_DR : PAUSE_DR;
				EXIT2_DR: state_d = tms_s ? UPDATE_DR : SHIFT_DR;
				UPDATE_DR: state_d = tms_s ? SELECT_DR : RUN_TEST_IDLE;
				SELECT_IR: state_d = tms_s ? TEST_LOGIC_RESET : CAPTURE_IR;
				CAPTURE_IR: state_d = tms_s ? EXIT1_IR : SHIFT_IR;
				SHIFT_IR: state_d = tms_s ? EXIT1_IR : SHIFT_IR;
				EXIT1_IR: state_d = tms_s ? UPDATE_IR : PAUSE_IR;
				PAUSE_IR: state_d = tms_s ? EXIT2_IR : PAUSE_IR;
				EXIT2_IR: state_d = tms_s ? UPDATE_IR : SHIFT_IR;
				UPDATE_IR: state_d = tms_s ? SELECT_DR : RUN_TEST_IDLE;
				default: state_d = TEST_LOGIC_RESET;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= TEST_LOGIC_RESET;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	assign state = state_q;
endmodule

// [verification/acbsc_sva.sv]
`timescale 1ns/1ps
module acbsc_sva
	import acbsc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic tck,
	input wire logic trst_n,
	input wire logic config_done,
	input wire logic tdo,
	input wire logic tdo_oe_n,
	input wire logic [1:0] serial_transceiver_pins,
	input acbsc_pkg::acbsc_mode_t mode,
	input acbsc_pkg::acbsc_tap_t tap_state
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	logic idle, ac, shf;
	logic [1:0] tx;
	assign idle = tap_state == RUN_TEST_IDLE;
	assign ac = mode inside {ACBSC_MODE_PULSE, ACBSC_MODE_TRAIN};
	assign shf = tap_state inside {SHIFT_IR, SHIFT_DR};
	assign tx = serial_transceiver_pins;
	property p_oe;
		!tdo_oe_n |-> shf || tap_state inside {EXIT1_IR, EXIT1_DR};
	endproperty
	a_oe: assert property (p_oe) else $error("tdo enabled off shift");
	property p_cfg;
		ac |-> config_done;
	endproperty
	a_cfg: assert property (p_cfg) else $error("ac mode unconfigured");
	property p_trst;
		!trst_n [*4] |=> tap_state == TEST_LOGIC_RESET;
	endproperty
	a_trst: assert property (p_trst) else $error("tap not reset");
	property p_rel;
		$fell(reset) |-> tap_state == TEST_LOGIC_RESET && tdo_oe_n;
	endproperty
	a_rel: assert property (p_rel) else $error("bad state after reset");
	property p_inv;
		ac && idle && $changed(tx) |-> tx == ~$past(tx);
	endproperty
	a_inv: assert property (p_inv) else $error("idle edge not inverted");
	property p_hold;
		mode == ACBSC_MODE_PULSE && idle && $past(idle, 16) |-> $stable(tx);
	endproperty
	a_hold: assert property (p_hold) else $error("pulse toggled twice");
	property p_fall;
		mode != ACBSC_MODE_FUNC && $changed(tx) |-> !tck;
	endproperty
	a_fall: assert property (p_fall) else $error("tx moved off falling");
	property p_tdo;
		$changed(tdo) |-> !tck;
	endproperty
	a_tdo: assert property (p_tdo) else $error("tdo moved off falling");
	c_pulse: cover property (mode == ACBSC_MODE_PULSE && idle && $changed(tx));
	c_train: cover property (mode == ACBSC_MODE_TRAIN && idle && $changed(tx));
	c_shift: cover property (!tdo_oe_n);
endmodule

// [verification/acbsc_host.sv]
`timescale 1ns/1ps
module acbsc_host (
	input wire logic clk,
	input wire logic tdo,
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n
);
	logic [9:0] so;
	task automatic park(input logic on);
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
		trst_n = !on;
	endtask
	initial park(1'h0);
	task automatic step(input logic m, input logic d);
		tms = m;
		tdi = d;
		repeat (10) @(negedge clk);
		tck = 1'h1;
		repeat (10) @(negedge clk);
		tck = 1'h0;
	endtask
	task automatic shift(input logic ir, input logic [9:0] v);
		if (ir && v inside {10'h310, 10'h0E5, 10'h0C9, 10'h313, 10'h0E6, 10'h02A})
			return;
		step(1'h1, 1'h1);
		if (ir)
			step(1'h1, 1'h1);
		step(1'h0, 1'h1);
		step(1'h0, 1'h1);
		for (int i = 0; i < 10; i++) begin
			step(i == 9, v[i]);
			so = {tdo, so[9:1]};
		end
		step(1'h1, 1'h1);
		step(1'h0, 1'h1);
	endtask
endmodule

// [verification/tb_acbsc_ctrl.sv]
`timescale 1ns/1ps
`include "acbsc_params.svh"
module tb_acbsc_ctrl;
	import acbsc_pkg::*;
	logic clk, reset, ce, tck, tms, tdi, trst_n, config_done, tdo, tdo_oe_n, watch;
	logic [3:0] core_out, pin_in, pin_out;
	logic [1:0] core_tx, serial_transceiver_pins, prev;
	acbsc_mode_t mode;
	acbsc_tap_t tap_state;
	logic [5:0] q[$];
	int failures, n_tests, cyc;
	acbsc_ctrl dut (.clk, .reset, .ce, .tck, .tms, .tdi, .trst_n, .config_done, .core_out,
		.core_tx, .pin_in, .tdo, .tdo_oe_n, .pin_out, .serial_transceiver_pins, .mode, .tap_state);
	acbsc_host host (.clk, .tdo, .tck, .tms, .tdi, .trst_n);
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		prev <= serial_transceiver_pins;
		if (watch && serial_transceiver_pins !== prev)
			check({serial_transceiver_pins, pin_out}, q.size() ? q.pop_front() : 10'h3FF);
		if (cyc == 30000) begin
			failures++;
			report_and_stop();
		end
	end
	task automatic run(input logic [9:0] code, input int n);
		logic [9:0] v;
		logic [5:0] p, d;
		watch = 1'h0;
		host.shift(1'h1, code);
		check(mode, {1'h1, code == `ACBSC_IR_TRAIN});
		v = 10'($urandom);
		host.shift(1'h0, v);
		p = v[9:4];
		repeat (8) @(negedge clk);
		watch = 1'h1;
		for (int i = 0; i < n; i++) begin
			v = 10'($urandom);
			v[9:8] = p[5:4] ^ 2'(i % 3 + 1);
			d = v[9:4];
			q.push_back(p);
			q.push_back(d);
			q.push_back(d ^ 6'h30);
			if (code == `ACBSC_IR_TRAIN) begin
				q.push_back(d);
				q.push_back(d ^ 6'h30);
			end
			host.shift(1'h0, v);
			host.step(1'h0, 1'h1);
			if (code == `ACBSC_IR_TRAIN)
				host.step(1'h0, 1'h1);
			p = d;
		end
		repeat (8) @(negedge clk);
		check(q.size(), 0);
		$display("walk %h done", code);
	endtask
	task automatic ext;
		logic [9:0] v;
		watch = 1'h0;
		v = 10'($urandom);
		host.shift(1'h1, `ACBSC_IR_EXTEST);
		check(mode, ACBSC_MODE_EXTEST);
		host.shift(1'h0, v);
		repeat (8) @(negedge clk);
		check({serial_transceiver_pins, pin_out}, v[9:4]);
		$display("extest done");
	endtask
	initial begin
		reset = 1'h1;
		ce = 1'h1;
		config_done = 1'h0;
		watch = 1'h0;
		void'($urandom(28));
		core_out = 4'($urandom);
		pin_in = 4'($urandom);
		core_tx = 2'h2;
		repeat (12) @(negedge clk);
		reset = 1'h0;
		@(negedge clk);
		check(tap_state, TEST_LOGIC_RESET);
		host.step(1'h0, 1'h1);
		host.shift(1'h1, `ACBSC_IR_PULSE);
		check(host.so, `ACBSC_IR_CAPTURE);
		check(mode, ACBSC_MODE_FUNC);
		core_tx = 2'($urandom);
		repeat (4) @(negedge clk);
		check(serial_transceiver_pins, core_tx);
		host.park(1'h1);
		config_done = 1'h1;
		repeat (8) @(negedge clk);
		check({tap_state, tdo_oe_n, mode}, {TEST_LOGIC_RESET, 1'h1, ACBSC_MODE_FUNC});
		host.park(1'h0);
		$display("gate and park done");
		host.step(1'h0, 1'h1);
		run(`ACBSC_IR_PULSE, 4);
		run(`ACBSC_IR_TRAIN, 4);
		ext();
		report_and_stop();
	end
endmodule
bind acbsc_ctrl acbsc_sva u_sva (.clk(clk), .reset(reset), .tck(tck), .trst_n(trst_n),
	.config_done(config_done), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
	.serial_transceiver_pins(serial_transceiver_pins), .mode(mode), .tap_state(tap_state));
